// >>> core/hpm_pin_mux.sv
// host port pin mux and report-pending interrupt
`timescale 1ns/1ps
`default_nettype none
module hpm_pin_mux (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // interrupt / transceiver enable pin, open drain
  output logic report_pending_irq_n_o,
  output logic report_pending_irq_n_oe_o,
  // first shared pin: sda / sck / rx
  input wire logic host_serial_data_i,
  output logic host_serial_data_o,
  output logic host_serial_data_oe_o,
  // second shared pin: scl / chip select / tx
  input wire logic host_serial_clock_i,
  output logic host_serial_clock_o,
  output logic host_serial_clock_oe_o,
  // mode strap pin, later miso
  input wire logic interface_mode_select_n_i,
  output logic interface_mode_select_n_o,
  output logic interface_mode_select_n_oe_o,
  // address strap pin, later mosi
  input wire logic bus_address_select_i,
  // report events from the core
  input wire logic report_new_i,
  input wire logic report_read_i,
  output logic [hpm_pkg::PEND_W-1:0] report_count_o,
  // mode straps from the core, taken at reset
  input wire logic lin_mode_i,
  input wire logic lin_irq_as_enable_i,
  output logic [1:0] mode_o,
  // protocol engine side
  input wire logic i2c_sda_drive_low_i,
  input wire logic i2c_scl_drive_low_i,
  input wire logic spi_miso_i,
  input wire logic lin_tx_i,
  input wire logic lin_transceiver_enable_i,
  output logic i2c_sda_o,
  output logic i2c_scl_o,
  output logic bus_address_select_o,
  output logic spi_sck_o,
  output logic host_chip_select_n_o,
  output logic spi_mosi_o,
  output logic lin_rx_o
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic a_in_s;
  logic b_in_s;
  logic mode_in_s;
  logic addr_in_s;

  localparam int N_SYNC = 4;
  logic [N_SYNC-1:0] pin_raw;
  logic [N_SYNC-1:0] pin_sync;

  assign pin_raw = {bus_address_select_i, interface_mode_select_n_i, host_serial_clock_i, host_serial_data_i};

  for (genvar gi = 0; gi < N_SYNC; gi++) begin : g_sync
    hpm_sync3 u_sync (.clk_i(clk_i), .pin_i(pin_raw[gi]), .level_o(pin_sync[gi]));
  end

  assign a_in_s = pin_sync[0];
  assign b_in_s = pin_sync[1];
  assign mode_in_s = pin_sync[2];
  assign addr_in_s = pin_sync[3];

  // ----------------------------------------
  // mode capture
  // ----------------------------------------
  hpm_pkg::hpm_mode_e mode_reg;
  logic lin_en_use_reg;
  hpm_pkg::hpm_mode_e strap_mode;

  assign strap_mode = lin_mode_i ? hpm_pkg::HPM_MODE_LIN :
                      (mode_in_s ? hpm_pkg::HPM_MODE_SPI : hpm_pkg::HPM_MODE_I2C);

  // straps are followed while reset is held and frozen at release
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mode_reg <= strap_mode;
      lin_en_use_reg <= lin_irq_as_enable_i;
    end
  end // no update outside reset

  logic is_i2c;
  logic is_spi;
  logic is_lin;
  assign is_i2c = (mode_reg == hpm_pkg::HPM_MODE_I2C);
  assign is_spi = (mode_reg == hpm_pkg::HPM_MODE_SPI);
  assign is_lin = (mode_reg == hpm_pkg::HPM_MODE_LIN);

  // ----------------------------------------
  // pending report counter
  // ----------------------------------------
  logic [hpm_pkg::PEND_W-1:0] pending_reg;
  logic [hpm_pkg::PEND_W-1:0] pending_next;
  logic do_inc;
  logic do_dec;

  // a new report arriving with a read leaves the count alone, so none is lost
  assign do_inc = report_new_i && !report_read_i && (pending_reg != hpm_pkg::PEND_MAX);
  assign do_dec = report_read_i && !report_new_i && (pending_reg != hpm_pkg::PEND_RESET);
  assign pending_next = do_inc ? pending_reg + hpm_pkg::PEND_ONE :
                        do_dec ? pending_reg - hpm_pkg::PEND_ONE : pending_reg;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pending_reg <= hpm_pkg::PEND_RESET;
    end else begin
      pending_reg <= pending_next;
    end
  end

  // ----------------------------------------
  // pin and user-side next values
  // ----------------------------------------
  logic lin_en_sel;
  logic irq_oe_next;
  logic a_oe_next;
  logic b_oe_next;
  logic b_out_next;
  logic m_oe_next;
  logic m_out_next;

  assign lin_en_sel = is_lin && lin_en_use_reg;
  // drive low = pending; release = pull-up only; in LIN use, low = transceiver off
  assign irq_oe_next = lin_en_sel ? !lin_transceiver_enable_i :
                       (pending_reg != hpm_pkg::PEND_RESET);
  assign a_oe_next = is_i2c && i2c_sda_drive_low_i;
  assign b_oe_next = (is_i2c && i2c_scl_drive_low_i) || is_lin;
  assign b_out_next = is_lin ? lin_tx_i : hpm_pkg::PIN_OUT_RESET;
  assign m_oe_next = is_spi;
  assign m_out_next = is_spi ? spi_miso_i : hpm_pkg::PIN_OUT_RESET;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      report_pending_irq_n_oe_o <= hpm_pkg::PIN_OE_RESET;
      host_serial_data_oe_o <= hpm_pkg::PIN_OE_RESET;
      host_serial_clock_oe_o <= hpm_pkg::PIN_OE_RESET;
      host_serial_clock_o <= hpm_pkg::PIN_OUT_RESET;
      interface_mode_select_n_oe_o <= hpm_pkg::PIN_OE_RESET;
      interface_mode_select_n_o <= hpm_pkg::PIN_OUT_RESET;
    end else begin
      report_pending_irq_n_oe_o <= irq_oe_next;
      host_serial_data_oe_o <= a_oe_next;
      host_serial_clock_oe_o <= b_oe_next;
      host_serial_clock_o <= b_out_next;
      interface_mode_select_n_oe_o <= m_oe_next;
      interface_mode_select_n_o <= m_out_next;
    end
  end

  // open-drain pins only ever drive low
  always_ff @(posedge clk_i) begin
    report_pending_irq_n_o <= hpm_pkg::PIN_OUT_RESET;
    host_serial_data_o <= hpm_pkg::PIN_OUT_RESET;
  end

  // inputs not used by the active mode sit at their idle level
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      i2c_sda_o <= hpm_pkg::IDLE_HIGH;
      i2c_scl_o <= hpm_pkg::IDLE_HIGH;
      bus_address_select_o <= hpm_pkg::IDLE_LOW;
      spi_sck_o <= hpm_pkg::IDLE_LOW;
      host_chip_select_n_o <= hpm_pkg::IDLE_HIGH;
      spi_mosi_o <= hpm_pkg::IDLE_LOW;
      lin_rx_o <= hpm_pkg::IDLE_HIGH;
    end else begin
      i2c_sda_o <= is_i2c ? a_in_s : hpm_pkg::IDLE_HIGH;
      spi_sck_o <= is_spi ? a_in_s : hpm_pkg::IDLE_LOW;
      lin_rx_o <= is_lin ? a_in_s : hpm_pkg::IDLE_HIGH;
      i2c_scl_o <= is_i2c ? b_in_s : hpm_pkg::IDLE_HIGH;
      host_chip_select_n_o <= is_spi ? b_in_s : hpm_pkg::IDLE_HIGH;
      bus_address_select_o <= is_i2c ? addr_in_s : hpm_pkg::IDLE_LOW;
      spi_mosi_o <= is_spi ? addr_in_s : hpm_pkg::IDLE_LOW;
    end
  end

  always_ff @(posedge clk_i) begin
    report_count_o <= pending_reg;
    mode_o <= mode_reg;
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_irq_assert;
    @(posedge clk_i) disable iff (reset_i)
      (pending_reg != hpm_pkg::PEND_RESET && !lin_en_sel) |=> (report_pending_irq_n_oe_o && !report_pending_irq_n_o);
  endproperty
  a_irq_assert: assert property (p_irq_assert) else $error("interrupt not driven low with reports pending");

  property p_irq_release;
    @(posedge clk_i) disable iff (reset_i)
      (pending_reg == hpm_pkg::PEND_RESET && !lin_en_sel) |=> !report_pending_irq_n_oe_o;
  endproperty
  a_irq_release: assert property (p_irq_release) else $error("interrupt driven with no reports pending");

  sequence s_read_only;
    report_read_i && !report_new_i && pending_reg != hpm_pkg::PEND_RESET;
  endsequence
  property p_consume;
    @(posedge clk_i) disable iff (reset_i)
      s_read_only |=> (pending_reg == $past(pending_reg) - hpm_pkg::PEND_ONE);
  endproperty
  a_consume: assert property (p_consume) else $error("host read did not consume a report");

  property p_lin_enable;
    @(posedge clk_i) disable iff (reset_i)
      lin_en_sel |=> (report_pending_irq_n_oe_o == !$past(lin_transceiver_enable_i));
  endproperty
  a_lin_enable: assert property (p_lin_enable) else $error("transceiver enable not on interrupt pin");

  property p_sck_in;
    @(posedge clk_i) disable iff (reset_i)
      is_spi |=> (!host_serial_data_oe_o && spi_sck_o == $past(a_in_s));
  endproperty
  a_sck_in: assert property (p_sck_in) else $error("first pin not spi clock input");

  property p_lin_rx;
    @(posedge clk_i) disable iff (reset_i)
      is_lin |=> (!host_serial_data_oe_o && lin_rx_o == $past(a_in_s));
  endproperty
  a_lin_rx: assert property (p_lin_rx) else $error("first pin not lin receive input");

  property p_chip_select;
    @(posedge clk_i) disable iff (reset_i)
      is_spi |=> (!host_serial_clock_oe_o && host_chip_select_n_o == $past(b_in_s));
  endproperty
  a_chip_select: assert property (p_chip_select) else $error("second pin not chip select input");

  property p_lin_tx;
    @(posedge clk_i) disable iff (reset_i)
      is_lin |=> (host_serial_clock_oe_o && host_serial_clock_o == $past(lin_tx_i));
  endproperty
  a_lin_tx: assert property (p_lin_tx) else $error("second pin not lin transmit output");

  property p_miso;
    @(posedge clk_i) disable iff (reset_i)
      is_spi |=> (interface_mode_select_n_oe_o && interface_mode_select_n_o == $past(spi_miso_i));
  endproperty
  a_miso: assert property (p_miso) else $error("mode pin not miso output in spi mode");

  property p_addr;
    @(posedge clk_i) disable iff (reset_i)
      is_i2c |=> (bus_address_select_o == $past(addr_in_s) && !interface_mode_select_n_oe_o);
  endproperty
  a_addr: assert property (p_addr) else $error("address pin not passed in i2c mode");

  property p_mode_hold;
    @(posedge clk_i) disable iff (reset_i)
      !$past(reset_i) |-> $stable(mode_reg);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed outside reset");

endmodule : hpm_pin_mux
`default_nettype wire

// >>> core/hpm_pkg.sv
// constants for the host port pin mux and report-pending interrupt
// Overview of operation
// - interrupt pin is driven low while at least one report waits for the host
// - with no reports pending the interrupt pin is released, weak pull-up only
// - each host read consumes one report; interrupt clears after the last one
// - in LIN mode the interrupt pin may serve as transceiver enable instead
// - first host pin: I2C data, SPI clock input, or LIN receive input
// - in LIN mode the first host pin receives data from the transceiver
// - second host pin: I2C clock, or active-low SPI chip select input
// - in LIN mode the second host pin drives transmit data to the transceiver
// - mode pin sampled at reset: low selects I2C, high SPI and it becomes MISO
// - address pin sets the I2C address, or is the SPI MOSI input
package hpm_pkg;

  // ----------------------------------------
  // interface modes
  // ----------------------------------------
  typedef enum logic [1:0] {
    HPM_MODE_I2C = 2'b00,
    HPM_MODE_SPI = 2'b01,
    HPM_MODE_LIN = 2'b10
  } hpm_mode_e;

  // ----------------------------------------
  // report counter
  // ----------------------------------------
  localparam int PEND_W = 8;
  localparam logic [PEND_W-1:0] PEND_RESET = 8'h00;
  localparam logic [PEND_W-1:0] PEND_ONE = 8'h01;
  localparam logic [PEND_W-1:0] PEND_MAX = 8'hff;

  // ----------------------------------------
  // reset values of pin drivers and user outputs
  // ----------------------------------------
  localparam logic PIN_OUT_RESET = 1'b0;
  localparam logic PIN_OE_RESET = 1'b0;
  localparam logic IDLE_HIGH = 1'b1;
  localparam logic IDLE_LOW = 1'b0;

endpackage : hpm_pkg

// >>> core/hpm_sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module hpm_sync3 (
  // clock
  input wire logic clk_i,
  // raw pin level
  input wire logic pin_i,
  // filtered level
  output logic level_o
);

  // ----------------------------------------
  // stages
  // ----------------------------------------
  // left unreset so the mode strap can be followed while reset is held
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;

  always_ff @(posedge clk_i) begin
    s1_reg <= pin_i;
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (s2_reg == s3_reg) begin
      level_reg <= s3_reg;
    end
  end

  assign level_o = level_reg;

endmodule : hpm_sync3
`default_nettype wire

// >>> testbench/hpm_host_model.sv
// host side of the shared pins, with the weak pull-ups resolved
`timescale 1ns/1ps
`default_nettype none
module hpm_host_model (
  // device pin drivers
  input wire logic irq_o_i,
  input wire logic irq_oe_i,
  input wire logic a_o_i,
  input wire logic a_oe_i,
  input wire logic b_o_i,
  input wire logic b_oe_i,
  input wire logic m_o_i,
  input wire logic m_oe_i,
  // host drive levels, 1 when released
  input wire logic host_a_i,
  input wire logic host_b_i,
  input wire logic host_m_i,
  // resolved pin levels
  output logic pin_a_o,
  output logic pin_b_o,
  output logic pin_m_o,
  output logic pin_irq_o,
  output logic irq_seen_o
);
  // ----------------------------------------
  // pin resolution
  // ----------------------------------------
  // a released open-drain pin floats up to the pull-up level
  assign pin_irq_o = irq_oe_i ? irq_o_i : 1'b1;
  // sensed by level so a report queued while busy is never missed
  assign irq_seen_o = ~pin_irq_o;
  assign pin_a_o = a_oe_i ? a_o_i : host_a_i;
  assign pin_b_o = b_oe_i ? b_o_i : host_b_i;
  assign pin_m_o = m_oe_i ? m_o_i : host_m_i;
endmodule : hpm_host_model
`default_nettype wire

// >>> testbench/hpm_pin_mux_tb.sv
// self-checking bench for the host pin mux
`timescale 1ns/1ps
`default_nettype none
module hpm_pin_mux_tb;
  logic clk_i, reset_i, report_new_i, report_read_i, lin_mode_i, lin_irq_as_enable_i, bus_address_select_i;
  logic i2c_sda_drive_low_i, i2c_scl_drive_low_i, spi_miso_i, lin_tx_i, lin_transceiver_enable_i;
  logic host_a, host_b, host_m, pin_a, pin_b, pin_m, pin_irq, irq_seen;
  logic report_pending_irq_n_o, report_pending_irq_n_oe_o, host_serial_data_o, host_serial_data_oe_o;
  logic host_serial_clock_o, host_serial_clock_oe_o, interface_mode_select_n_o, interface_mode_select_n_oe_o;
  logic [hpm_pkg::PEND_W-1:0] report_count_o;
  logic [1:0] mode_o;
  logic i2c_sda_o, i2c_scl_o, bus_address_select_o, spi_sck_o, host_chip_select_n_o, spi_mosi_o, lin_rx_o;
  int n_fail, num_checks, cycles;

  hpm_pin_mux dut_u (.clk_i, .reset_i, .report_pending_irq_n_o, .report_pending_irq_n_oe_o,
    .host_serial_data_i(pin_a), .host_serial_data_o, .host_serial_data_oe_o,
    .host_serial_clock_i(pin_b), .host_serial_clock_o, .host_serial_clock_oe_o,
    .interface_mode_select_n_i(pin_m), .interface_mode_select_n_o, .interface_mode_select_n_oe_o,
    .bus_address_select_i, .report_new_i, .report_read_i, .report_count_o, .lin_mode_i,
    .lin_irq_as_enable_i, .mode_o, .i2c_sda_drive_low_i, .i2c_scl_drive_low_i, .spi_miso_i, .lin_tx_i,
    .lin_transceiver_enable_i, .i2c_sda_o, .i2c_scl_o, .bus_address_select_o, .spi_sck_o,
    .host_chip_select_n_o, .spi_mosi_o, .lin_rx_o);

  hpm_host_model host_u (.irq_o_i(report_pending_irq_n_o), .irq_oe_i(report_pending_irq_n_oe_o),
    .a_o_i(host_serial_data_o), .a_oe_i(host_serial_data_oe_o), .b_o_i(host_serial_clock_o),
    .b_oe_i(host_serial_clock_oe_o),
    .m_o_i(interface_mode_select_n_o), .m_oe_i(interface_mode_select_n_oe_o), .host_a_i(host_a),
    .host_b_i(host_b), .host_m_i(host_m), .pin_a_o(pin_a), .pin_b_o(pin_b), .pin_m_o(pin_m),
    .pin_irq_o(pin_irq), .irq_seen_o(irq_seen));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // hang guard, far above the roughly 85 cycles the run needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task report_and_stop;
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  // the short delay lets the edge's register updates land first
  task check(input logic [7:0] seen, input logic [7:0] exp);
    #1;
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc

  // strap inputs are held for six edges so the unreset sync chains settle
  task do_reset(input logic lin, input logic en, input logic strap);
    @(posedge clk_i);
    reset_i <= 1'b1;
    lin_mode_i <= lin;
    lin_irq_as_enable_i <= en;
    host_m <= strap;
    host_a <= 1'b1;
    host_b <= 1'b1;
    cyc(6);
    reset_i <= 1'b0;
    cyc(2);
  endtask : do_reset

  // each read pulse stands for the host consuming one report
  task rep(input logic nw, input logic rd);
    @(posedge clk_i);
    report_new_i <= nw;
    report_read_i <= rd;
    @(posedge clk_i);
    report_new_i <= 1'b0;
    report_read_i <= 1'b0;
  endtask : rep

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reports;
    rep(1'b1, 1'b0);
    rep(1'b1, 1'b0);
    cyc(3);
    check(irq_seen, 8'h01);
    check(report_count_o, 8'h02);
    rep(1'b1, 1'b1);
    rep(1'b0, 1'b1);
    cyc(3);
    check(irq_seen, 8'h01);
    rep(1'b0, 1'b1);
    cyc(3);
    check(pin_irq, 8'h01);
    check(report_pending_irq_n_oe_o, 8'h00);
    rep(1'b0, 1'b1);
    cyc(3);
    check(report_count_o, 8'h00);
  endtask : t_reports

  task t_i2c;
    check(mode_o, hpm_pkg::HPM_MODE_I2C);
    @(posedge clk_i);
    host_a <= 1'b0;
    host_b <= 1'b0;
    bus_address_select_i <= 1'b1;
    host_m <= 1'b1;
    cyc(6);
    check(i2c_sda_o, 8'h00);
    check(i2c_scl_o, 8'h00);
    check(bus_address_select_o, 8'h01);
    check(mode_o, hpm_pkg::HPM_MODE_I2C);
    @(posedge clk_i);
    host_a <= 1'b1;
    host_b <= 1'b1;
    i2c_sda_drive_low_i <= 1'b1;
    i2c_scl_drive_low_i <= 1'b1;
    cyc(2);
    check(pin_a, 8'h00);
    check(pin_b, 8'h00);
    @(posedge clk_i);
    i2c_sda_drive_low_i <= 1'b0;
    i2c_scl_drive_low_i <= 1'b0;
    cyc(2);
    check(pin_a, 8'h01);
    check(pin_b, 8'h01);
  endtask : t_i2c

  task t_spi;
    check(mode_o, hpm_pkg::HPM_MODE_SPI);
    @(posedge clk_i);
    spi_miso_i <= 1'b0;
    host_b <= 1'b0;
    bus_address_select_i <= 1'b1;
    cyc(6);
    check(pin_m, 8'h00);
    check(spi_sck_o, 8'h01);
    check(host_chip_select_n_o, 8'h00);
    check(spi_mosi_o, 8'h01);
    check(i2c_sda_o, 8'h01);
    @(posedge clk_i);
    spi_miso_i <= 1'b1;
    cyc(2);
    check(pin_m, 8'h01);
  endtask : t_spi

  task t_lin;
    check(mode_o, hpm_pkg::HPM_MODE_LIN);
    @(posedge clk_i);
    lin_tx_i <= 1'b0;
    host_a <= 1'b0;
    lin_transceiver_enable_i <= 1'b0;
    cyc(6);
    check(pin_b, 8'h00);
    check(lin_rx_o, 8'h00);
    check(report_pending_irq_n_oe_o, 8'h01);
    @(posedge clk_i);
    lin_tx_i <= 1'b1;
    lin_transceiver_enable_i <= 1'b1;
    cyc(2);
    check(pin_b, 8'h01);
    check(report_pending_irq_n_oe_o, 8'h00);
  endtask : t_lin

  initial begin
    {reset_i, report_new_i, report_read_i, lin_mode_i, lin_irq_as_enable_i} = 5'h10;
    {i2c_sda_drive_low_i, i2c_scl_drive_low_i, spi_miso_i, bus_address_select_i} = 4'h0;
    {lin_tx_i, lin_transceiver_enable_i, host_a, host_b, host_m} = 5'h1e;
    {n_fail, num_checks, cycles} = '0;
    do_reset(1'b0, 1'b0, 1'b0);
    t_reports();
    t_i2c();
    do_reset(1'b0, 1'b0, 1'b1);
    t_spi();
    do_reset(1'b1, 1'b1, 1'b0);
    t_lin();
    report_and_stop();
  end
endmodule : hpm_pin_mux_tb
`default_nettype wire
